/* File: xpr_far_side_model.sv */
// Purpose: Far side model, word assembler and character logic
// Assumes: Requests come from the bench as one-cycle pulses
// Notes:   Data is inverted once released so stale values never match
`timescale 1ns/100ps
module xpr_far_side_model (
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [1:0] load_req_in,
  input  wire logic [4:0] load_data_in,
  input  wire logic       glyph_req_in,
  input  wire logic       advance_done_in,
  output logic      [4:0] data_bus_out,
  output logic            low_strobe_out,
  output logic            high_strobe_out,
  output logic            glyph_done_out,
  output logic      [7:0] done_count_out
);
  logic [1:0] sel_reg;
  logic [1:0] phase_reg;
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      data_bus_out    <= 5'h00;
      sel_reg         <= 2'h0;
      phase_reg       <= 2'h0;
      low_strobe_out  <= 1'b0;
      high_strobe_out <= 1'b0;
      glyph_done_out  <= 1'b0;
      done_count_out  <= 8'h00;
    end else begin
      glyph_done_out <= glyph_req_in;
      if (advance_done_in) begin
        done_count_out <= done_count_out + 8'h01;
      end
      case (phase_reg)
        2'h0: if (|load_req_in) begin
          data_bus_out <= load_data_in;
          sel_reg      <= load_req_in;
          phase_reg    <= 2'h1;
        end
        2'h1: begin
          low_strobe_out  <= sel_reg[0];
          high_strobe_out <= sel_reg[1];
          phase_reg       <= 2'h2;
        end
        default: begin
          low_strobe_out  <= 1'b0;
          high_strobe_out <= 1'b0;
          data_bus_out    <= ~data_bus_out;
          phase_reg       <= 2'h0;
        end
      endcase
    end
  end
endmodule : xpr_far_side_model

/* File: xpr_pkg.sv */
// Purpose: Shared constants and types for the horizontal position register
// Assumes: 20 MHz core clock; 2 MHz character timing derived internally
// Notes:   Positions are in points, twelve points per character place
package xpr_pkg;

  localparam int unsigned CORE_PERIOD_NS  = 50;
  localparam int unsigned SLOW_PERIOD_NS  = 500;
  localparam int unsigned SLOW_DIV        = SLOW_PERIOD_NS / CORE_PERIOD_NS;
  localparam int unsigned SLOW_HALF       = SLOW_DIV / 2;

  localparam int unsigned POS_W           = 10;
  localparam int unsigned LOW_W           = 4;
  localparam int unsigned HIGH_W          = 5;
  localparam int unsigned DATA_W          = 5;
  localparam int unsigned PTS_PER_CHAR    = 12;

  localparam logic [3:0] DIV_LAST         = 4'(SLOW_DIV - 1);
  localparam logic [3:0] DIV_FALL         = 4'(SLOW_HALF);
  localparam logic [3:0] SPACE_LAST       = 4'(PTS_PER_CHAR - 1);

  localparam int unsigned BELL_CHAR_HORIZ = 78;
  localparam int unsigned BELL_CHAR_VERT  = 67;
  localparam int unsigned END_CHAR_HORIZ  = 85;

  localparam logic [9:0] BELL_H_LO  = 10'((BELL_CHAR_HORIZ - 1) * PTS_PER_CHAR);
  localparam logic [9:0] BELL_H_HI  = 10'(BELL_CHAR_HORIZ * PTS_PER_CHAR - 1);
  localparam logic [9:0] BELL_V_LO  = 10'((BELL_CHAR_VERT - 1) * PTS_PER_CHAR);
  localparam logic [9:0] BELL_V_HI  = 10'(BELL_CHAR_VERT * PTS_PER_CHAR - 1);
  localparam logic [9:0] LINE_END_POS   = 10'(END_CHAR_HORIZ * PTS_PER_CHAR);
  localparam logic [9:0] LINE_START_TOP = 10'(PTS_PER_CHAR - 1);

  localparam logic [3:0] LOW_RST    = 4'h0;
  localparam logic [3:0] LOW_MAX    = 4'hF;
  localparam logic [4:0] HIGH_LOWER_RST = 5'h00;

  typedef struct packed {
    logic [4:0] high;
    logic       fifth;
    logic [3:0] low;
  } xpr_pos_t;

  typedef enum logic [1:0] {
    XPR_EOL_IDLE,
    XPR_EOL_ARMED,
    XPR_EOL_PULSE
  } xpr_eol_t;

endpackage : xpr_pkg

/* File: xpr_step_ctr.sv */
// Purpose: Loadable up/down counter section with wrap carry and borrow
// Assumes: Load wins over counting; up and down never asserted together
// Notes:   Carry and borrow are combinational, valid in the step cycle
`timescale 1ns/100ps
module xpr_step_ctr #(
  parameter int unsigned W = 4
) (
  input  wire logic         core_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_val_in,
  input  wire logic         up_in,
  input  wire logic         dn_in,
  output logic      [W-1:0] count_out,
  output logic              carry_out,
  output logic              borrow_out
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  assign carry_out  = up_in & ~load_in & (&count_reg);
  assign borrow_out = dn_in & ~load_in & ~(|count_reg);
  assign count_out  = count_reg;

  assign count_next = load_in ? load_val_in :
                      up_in   ? W'(count_reg + 1'b1) :
                      dn_in   ? W'(count_reg - 1'b1) : count_reg;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : xpr_step_ctr

/* File: xpr_x_position.sv */
// Purpose: Ten-bit horizontal beam position register with margins and spacing
// Assumes: All command inputs are one-cycle pulses from logic on core_clk_in
// Notes:   The 2 MHz character timing is a tick pair derived from core_clk_in
//
// Summary of operation
// - Ten-bit position: low four-bit counter, fifth bit, high five-bit counter.
// - Clear command zeroes low counter and fifth bit together.
// - Each up step from plot, external or space source adds one.
// - Low counter at fifteen wraps to zero on up, carry toggles fifth bit.
// - Carry bumps high section only when fifth bit set, which then clears.
// - Down direction blocks up path and routes steps to down input.
// - Low zero wraps to fifteen on down; borrow toggles fifth, maybe decrements high.
// - Low load strobe takes four data bits and fifth bit from data.
// - High load strobe loads the high section from the same data lines.
// - Return commands zero lower nine bits, top bit follows margin.
// - Left margin gives zero, centre margin select gives position 512.
// - With automatic return, each line end pulse triggers a margin return.
// - Bell on keyboard strobe at character 78 horizontal or 67 vertical.
// - Text mode at first character place blocks all down steps.
// - Horizontal format after character 85 flags line end, blocks up steps.
// - Line end runs two falling-edge stages; low pulse spans one slow period.
// - Text mode with overlay low: glyph done starts a space sequence.
// - Each slow rising edge in a space gives a half-period low step.
// - Exactly twelve steps per space; divide-by-twelve ends on twelfth.
`timescale 1ns/100ps
module xpr_x_position (
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [4:0] data_bus_in,
  input  wire logic       low_half_load_strobe_in,
  input  wire logic       high_half_load_strobe_in,
  input  wire logic       clear_cmd_in,
  input  wire logic       home_cmd_in,
  input  wire logic       carriage_return_command_in,
  input  wire logic       centre_margin_select_in,
  input  wire logic       left_margin_select_in,
  input  wire logic       automatic_return_option_in,
  input  wire logic       count_down_in,
  input  wire logic       aux_plot_step_in,
  input  wire logic       ext_step_in,
  input  wire logic       text_mode_in,
  input  wire logic       overlay_mode_line_in,
  input  wire logic       glyph_done_in,
  input  wire logic       horiz_format_in,
  input  wire logic       keyboard_strobe_in,
  output xpr_pkg::xpr_pos_t position_out,
  output logic            fifth_position_bit_out,
  output logic            top_position_bit_out,
  output logic            centre_margin_out,
  output logic            margin_bell_out,
  output logic            line_end_out,
  output logic            line_end_pulse_n_out,
  output logic            space_active_out,
  output logic            space_step_n_out,
  output logic            advance_done_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Slow timing ticks

  logic [3:0] div_reg;
  logic       rise_tick;
  logic       fall_tick;

  assign rise_tick = (div_reg == 4'h0);
  assign fall_tick = (div_reg == xpr_pkg::DIV_FALL);

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= (div_reg == xpr_pkg::DIV_LAST) ? 4'h0 : 4'(div_reg + 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Margin and reset logic

  logic       centre_reg;
  logic       centre_next;
  logic       eol_end;
  logic       return_go;
  logic       low_clear;

  assign centre_next = centre_margin_select_in ? 1'b1 :
                       left_margin_select_in   ? 1'b0 : centre_reg;
  // Auto return fires as the line end pulse finishes
  assign return_go   = home_cmd_in | carriage_return_command_in | centre_margin_select_in
                     | left_margin_select_in | (automatic_return_option_in & eol_end);
  assign low_clear   = clear_cmd_in | return_go;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      centre_reg <= 1'b0;
    end else begin
      centre_reg <= centre_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step sources and direction gating

  logic [9:0] pos;
  logic       space_step;
  logic       step_any;
  logic       line_start;
  logic       line_end;
  logic       low_up;
  logic       low_dn;

  assign step_any   = aux_plot_step_in | ext_step_in | space_step;
  assign line_start = text_mode_in & (pos <= xpr_pkg::LINE_START_TOP);
  assign line_end   = horiz_format_in & (pos >= xpr_pkg::LINE_END_POS);
  // Loads and returns take priority, so steps in those cycles are dropped
  assign low_up     = step_any & ~count_down_in & ~line_end;
  assign low_dn     = step_any &  count_down_in & ~line_start;

  ////////////////////////////////////////////////////////////////////////////
  // Low section, fifth bit and high section

  logic [3:0] low_cnt;
  logic [4:0] high_cnt;
  logic       low_carry;
  logic       low_borrow;
  logic       low_load;
  logic [3:0] low_load_val;
  logic       high_load;
  logic [4:0] high_load_val;
  logic       fifth_reg;
  logic       fifth_next;

  assign low_load      = low_clear | low_half_load_strobe_in;
  assign low_load_val  = low_clear ? xpr_pkg::LOW_RST : data_bus_in[3:0];
  assign high_load     = return_go | high_half_load_strobe_in;
  assign high_load_val = return_go ? {centre_next, xpr_pkg::HIGH_LOWER_RST[3:0]}
                                   : data_bus_in;

  xpr_step_ctr #(.W(xpr_pkg::LOW_W)) u_low (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .load_in     (low_load),
    .load_val_in (low_load_val),
    .up_in       (low_up & ~high_load),
    .dn_in       (low_dn & ~high_load),
    .count_out   (low_cnt),
    .carry_out   (low_carry),
    .borrow_out  (low_borrow)
  );

  xpr_step_ctr #(.W(xpr_pkg::HIGH_W)) u_high (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .load_in     (high_load | low_load),
    .load_val_in (high_load ? high_load_val : high_cnt),
    .up_in       (low_carry & fifth_reg),
    .dn_in       (low_borrow & ~fifth_reg),
    .count_out   (high_cnt),
    .carry_out   (),
    .borrow_out  ()
  );

  // Carry and borrow both toggle the fifth bit
  assign fifth_next = low_clear               ? 1'b0 :
                      low_half_load_strobe_in ? data_bus_in[4] :
                      (low_carry | low_borrow) ? ~fifth_reg : fifth_reg;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fifth_reg <= 1'b0;
    end else begin
      fifth_reg <= fifth_next;
    end
  end

  assign pos = {high_cnt, fifth_reg, low_cnt};

  ////////////////////////////////////////////////////////////////////////////
  // Margin bell

  logic bell_reg;
  logic bell_zone;

  assign bell_zone = horiz_format_in ?
                     (pos >= xpr_pkg::BELL_H_LO && pos <= xpr_pkg::BELL_H_HI) :
                     (pos >= xpr_pkg::BELL_V_LO && pos <= xpr_pkg::BELL_V_HI);

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bell_reg <= 1'b0;
    end else begin
      bell_reg <= keyboard_strobe_in & bell_zone;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line end pulse chain

  xpr_pkg::xpr_eol_t eol_state;
  xpr_pkg::xpr_eol_t eol_next;
  logic              line_end_d_reg;
  logic              eol_pend_reg;
  logic              line_end_rise;

  // Only a fresh line end arms the chain, so a parked beam rings once
  assign line_end_rise = line_end & ~line_end_d_reg;
  assign eol_end       = fall_tick & (eol_state == xpr_pkg::XPR_EOL_PULSE);

  always_comb begin
    eol_next = eol_state;
    case (eol_state)
      xpr_pkg::XPR_EOL_IDLE: begin
        if (fall_tick && eol_pend_reg) begin
          eol_next = xpr_pkg::XPR_EOL_ARMED;
        end
      end
      xpr_pkg::XPR_EOL_ARMED: begin
        if (fall_tick) begin
          eol_next = xpr_pkg::XPR_EOL_PULSE;
        end
      end
      xpr_pkg::XPR_EOL_PULSE: begin
        if (fall_tick) begin
          eol_next = xpr_pkg::XPR_EOL_IDLE;
        end
      end
      default: eol_next = xpr_pkg::XPR_EOL_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      eol_state      <= xpr_pkg::XPR_EOL_IDLE;
      line_end_d_reg <= 1'b0;
      eol_pend_reg   <= 1'b0;
    end else begin
      eol_state      <= eol_next;
      line_end_d_reg <= line_end;
      if (line_end_rise) begin
        eol_pend_reg <= 1'b1;
      end else if (fall_tick && eol_state == xpr_pkg::XPR_EOL_IDLE) begin
        eol_pend_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Space sequence

  logic       space_reg;
  logic [3:0] space_cnt_reg;
  logic       step_low_reg;
  logic       done_reg;
  logic       space_start;
  logic       space_last;

  assign space_start = text_mode_in & ~overlay_mode_line_in & glyph_done_in & ~space_reg;
  assign space_step  = space_reg & rise_tick;
  assign space_last  = space_step & (space_cnt_reg == xpr_pkg::SPACE_LAST);

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      space_reg     <= 1'b0;
      space_cnt_reg <= 4'h0;
      step_low_reg  <= 1'b0;
      done_reg      <= 1'b0;
    end else begin
      done_reg <= space_last;
      if (space_start) begin
        space_reg <= 1'b1;
      end else if (space_last) begin
        space_reg <= 1'b0;
      end
      if (space_last) begin
        space_cnt_reg <= 4'h0;
      end else if (space_step) begin
        space_cnt_reg <= 4'(space_cnt_reg + 1'b1);
      end
      if (space_step) begin
        step_low_reg <= 1'b1;
      end else if (fall_tick) begin
        step_low_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign position_out           = xpr_pkg::xpr_pos_t'(pos);
  assign fifth_position_bit_out = fifth_reg;
  assign top_position_bit_out   = high_cnt[4];
  assign centre_margin_out      = centre_reg;
  assign margin_bell_out        = bell_reg;
  assign line_end_out           = line_end_d_reg;
  assign line_end_pulse_n_out   = ~(eol_state == xpr_pkg::XPR_EOL_PULSE);
  assign space_active_out       = space_reg;
  assign space_step_n_out       = ~step_low_reg;
  assign advance_done_out       = done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_up_wrap;
    low_up && !low_load && !high_load && low_cnt == 4'hF;
  endsequence

  up_wrap_a: assert property (s_up_wrap |=> low_cnt == 4'h0
    && fifth_reg != $past(fifth_reg)) else $error("up wrap wrong");

  carry_high_a: assert property ((s_up_wrap and fifth_reg) |=>
    high_cnt == 5'($past(high_cnt) + 1'b1) && !fifth_reg) else $error("carry into high wrong");

  down_wrap_a: assert property (low_dn && !low_load && !high_load && low_cnt == 4'h0
    |=> low_cnt == 4'hF && fifth_reg != $past(fifth_reg)) else $error("down wrap wrong");

  low_load_a: assert property (low_half_load_strobe_in && !low_clear
    |=> {fifth_reg, low_cnt} == $past(data_bus_in)) else $error("low load wrong");

  return_pos_a: assert property (return_go
    |=> pos[8:0] == 9'h000 && pos[9] == centre_reg) else $error("return position wrong");

  start_block_a: assert property (text_mode_in && pos == 10'h000 && count_down_in
    && step_any && !low_load && !high_load |=> pos == 10'h000) else $error("down at line start");

  bell_pulse_a: assert property (keyboard_strobe_in && horiz_format_in
    && pos == xpr_pkg::BELL_H_LO |=> margin_bell_out) else $error("bell missing");

  sequence s_eol_low;
    !line_end_pulse_n_out [*8] ##1 !line_end_pulse_n_out [*2];
  endsequence

  eol_width_a: assert property ($fell(line_end_pulse_n_out) |-> s_eol_low
    ##1 (line_end_pulse_n_out && fall_tick == 1'b0)) else $error("line end pulse width wrong");

  step_half_a: assert property ($fell(space_step_n_out) |->
    (!space_step_n_out) [*5] ##1 space_step_n_out) else $error("space step width wrong");

  space_len_a: assert property (space_start |=> space_reg [*8] ##0
    (space_reg ##[1:120] done_reg)) else $error("space sequence length wrong");

  done_clear_a: assert property (done_reg |-> !space_reg
    && $past(space_cnt_reg) == xpr_pkg::SPACE_LAST) else $error("advance done wrong");

endmodule : xpr_x_position

/* File: xpr_x_position_test.sv */
// Purpose: Self-checking bench for the horizontal position register
// Assumes: Inputs change by non-blocking assignment on the rising edge
// Notes:   Auto return stays off in the random part so positions stay predictable
`timescale 1ns/100ps
module xpr_x_position_test;
  logic              core_clk_in, sys_rst_in;
  logic [7:0]        cmd_v;
  logic [1:0]        load_req;
  logic [4:0]        load_data, data_bus;
  logic              glyph_req, glyph_done, lo_stb, hi_stb;
  logic              auto_ret, count_dn, text_m, overlay, horiz;
  xpr_pkg::xpr_pos_t pos_s;
  logic [9:0]        pos_w, exp_pos;
  logic              fifth, top, centre, bell, l_end, l_end_n, sp_act, sp_step_n, adv;
  logic [7:0]        done_cnt;
  logic [31:0]       rng;
  logic              bell_seen, prev_n;
  int                failures, tests_run, n;
  assign pos_w = pos_s;
  ////////////////////////////////////////////////////////////////////////////////
  xpr_far_side_model far_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .load_req_in(load_req), .load_data_in(load_data), .glyph_req_in(glyph_req),
    .advance_done_in(adv), .data_bus_out(data_bus), .low_strobe_out(lo_stb),
    .high_strobe_out(hi_stb), .glyph_done_out(glyph_done), .done_count_out(done_cnt));
  xpr_x_position dut_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .data_bus_in(data_bus), .low_half_load_strobe_in(lo_stb),
    .high_half_load_strobe_in(hi_stb), .clear_cmd_in(cmd_v[0]), .home_cmd_in(cmd_v[1]),
    .carriage_return_command_in(cmd_v[2]), .centre_margin_select_in(cmd_v[3]),
    .left_margin_select_in(cmd_v[4]), .automatic_return_option_in(auto_ret),
    .count_down_in(count_dn), .aux_plot_step_in(cmd_v[5]), .ext_step_in(cmd_v[6]),
    .text_mode_in(text_m), .overlay_mode_line_in(overlay), .glyph_done_in(glyph_done),
    .horiz_format_in(horiz), .keyboard_strobe_in(cmd_v[7]), .position_out(pos_s),
    .fifth_position_bit_out(fifth), .top_position_bit_out(top),
    .centre_margin_out(centre), .margin_bell_out(bell), .line_end_out(l_end),
    .line_end_pulse_n_out(l_end_n), .space_active_out(sp_act),
    .space_step_n_out(sp_step_n), .advance_done_out(adv));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Plain binary arithmetic is what the cascaded sections amount to
  function automatic logic [9:0] next_pos(input logic [9:0] p, input logic dn,
                                          input logic hz, input logic tx);
    if (dn) begin
      return (tx && p <= 10'h00B) ? p : p - 10'h001;
    end
    return (hz && p >= 10'h3FC) ? p : p + 10'h001;
  endfunction : next_pos
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  task automatic pulse(input int k);
    @(posedge core_clk_in); cmd_v[k] <= 1'b1;
    @(posedge core_clk_in); cmd_v[k] <= 1'b0;
    @(negedge core_clk_in); bell_seen = bell;
    check(16'({top, fifth}), 16'({pos_w[9], pos_w[4]}));
  endtask : pulse
  task automatic step(input logic dn, input int k);
    @(posedge core_clk_in); count_dn <= dn;
    pulse(k);
  endtask : step
  task automatic load_half(input logic [1:0] sel, input logic [4:0] v);
    @(posedge core_clk_in); load_req <= sel; load_data <= v;
    @(posedge core_clk_in); load_req <= 2'h0;
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask : load_half
  task automatic set_pos(input logic [9:0] v);
    load_half(2'h2, v[9:5]);
    load_half(2'h1, v[4:0]);
    check(16'(pos_w), 16'(v));
  endtask : set_pos
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  initial begin
    #(20000 * 50);
    failures++;
    finish_test();
  end
  initial begin
    logic [9:0] corner [8];
    corner = '{10'h000, 10'h00F, 10'h010, 10'h01F, 10'h020, 10'h00B, 10'h00C, 10'h1FF};
    rng = 32'h0000004A;
    failures = 0; tests_run = 0;
    sys_rst_in = 1'b1; cmd_v = 8'h00; load_req = 2'h0; load_data = 5'h00;
    glyph_req = 1'b0; auto_ret = 1'b0; count_dn = 1'b0; text_m = 1'b0;
    overlay = 1'b0; horiz = 1'b1;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(negedge core_clk_in);
    check(16'({pos_w, centre, l_end_n, sp_step_n, adv}), 16'h0006);
    // Corner steps both ways, then random ones
    for (int i = 0; i < 48; i++) begin
      rng = xs(rng);
      if (i < 16) begin
        @(posedge core_clk_in); text_m <= i[3]; horiz <= 1'b1;
        set_pos(corner[i % 8]);
      end else begin
        @(posedge core_clk_in); text_m <= rng[3]; horiz <= rng[4];
        if (rng[5]) set_pos(rng[31:22]);
      end
      @(negedge core_clk_in);
      exp_pos = next_pos(pos_w, (i < 16) ? (i[0] ^ i[3]) : rng[0], horiz, text_m);
      step((i < 16) ? (i[0] ^ i[3]) : rng[0], rng[1] ? 5 : 6);
      check(16'(pos_w), 16'(exp_pos));
    end
    @(posedge core_clk_in); text_m <= 1'b0; horiz <= 1'b1;
    // Margins and returns
    set_pos(10'h12C); pulse(3);
    check(16'({pos_w, centre}), 16'h0401);
    check(16'({top, fifth, centre}), 16'h0005);
    set_pos(10'h04D); pulse(0);
    check(16'(pos_w), 16'h0040);
    set_pos(10'h3F3); pulse(1);
    check(16'(pos_w), 16'h0200);
    set_pos(10'h155); pulse(2);
    check(16'(pos_w), 16'h0200);
    pulse(4);
    check(16'({pos_w, centre}), 16'h0000);
    set_pos(10'h2BC); pulse(2);
    check(16'(pos_w), 16'h0000);
    // Bell zone edges in both formats
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk_in); horiz <= (i < 4) || (i == 7);
      set_pos(i == 7 ? 10'h318 : (i < 4 ? 10'h39C : 10'h318) + 10'(i % 4 == 1 ? 11 : 0)
              - 10'(i % 4 == 2 ? 1 : 0) + 10'(i % 4 == 3 ? 12 : 0));
      pulse(7);
      check(16'(bell_seen), 16'(i % 4 < 2 && i != 7));
    end
    // Line end: up blocked, pulse length, automatic return
    @(posedge core_clk_in); horiz <= 1'b1; auto_ret <= 1'b1;
    pulse(4); set_pos(10'h3FB); step(1'b0, 6);
    step(1'b0, 5);
    check(16'({pos_w, l_end}), 16'h07F9);
    n = 0;
    while (l_end_n !== 1'b0 && n < 60) begin @(negedge core_clk_in); n++; end
    n = 0;
    while (l_end_n === 1'b0 && n < 30) begin @(negedge core_clk_in); n++; end
    check(16'(n), 16'h000A);
    repeat (2) @(negedge core_clk_in);
    check(16'(pos_w), 16'h0000);
    // Space: refused with overlay high, then a full twelve-point advance
    @(posedge core_clk_in); auto_ret <= 1'b0; text_m <= 1'b1; overlay <= 1'b1;
    set_pos(10'h064);
    @(posedge core_clk_in); glyph_req <= 1'b1;
    @(posedge core_clk_in); glyph_req <= 1'b0;
    repeat (3) @(negedge core_clk_in);
    check(16'({pos_w, sp_act}), 16'h00C8);
    @(posedge core_clk_in); overlay <= 1'b0; glyph_req <= 1'b1;
    @(posedge core_clk_in); glyph_req <= 1'b0;
    repeat (2) @(negedge core_clk_in);
    check(16'(sp_act), 16'h0001);
    n = 0; prev_n = 1'b1;
    for (int c = 0; c < 300 && adv !== 1'b1; c++) begin
      @(negedge core_clk_in);
      if (prev_n === 1'b1 && sp_step_n === 1'b0) n++;
      prev_n = sp_step_n;
    end
    check(16'(n), 16'h000C);
    @(negedge core_clk_in);
    check(16'(pos_w), 16'h0070);
    check(16'({sp_act, done_cnt}), 16'h0001);
    finish_test();
  end
endmodule : xpr_x_position_test
